/* logic/uifc_pkg.sv */
// Constants, register map and state encodings for the in-band flow control block.
// Assumes a 32-bit APB master on one 100 MHz clock.
package uifc_pkg;
    // ========================================================================
    // Register indices (printed offset not a multiple of four: byte = 4*index)
    localparam logic [7:0]  UIFC_IDX_MODE      = 8'h23;
    localparam logic [7:0]  UIFC_IDX_CMD       = 8'h24;
    localparam logic [7:0]  UIFC_IDX_ISR       = 8'h25;
    localparam logic [7:0]  UIFC_IDX_IMR       = 8'h26;
    localparam logic [7:0]  UIFC_IDX_XON       = 8'h27;
    localparam logic [7:0]  UIFC_IDX_XOFF      = 8'h28;
    localparam logic [7:0]  UIFC_IDX_STAT      = 8'h29;
    localparam logic [7:0]  UIFC_IDX_ADDR      = 8'h2A;
    localparam logic [7:0]  UIFC_IDX_RXMODE    = 8'h2B;
    // ========================================================================
    // Mode register fields and reset values
    localparam int          UIFC_MODE_FC_STRIP = 7;
    localparam int          UIFC_MODE_AD_STRIP = 6;
    localparam int          UIFC_MODE_FC_LO    = 2;
    localparam logic [7:0]  UIFC_MODE_RST      = 8'h00;
    localparam logic [7:0]  UIFC_MODE_WMASK    = 8'hCF;
    localparam logic [7:0]  UIFC_XON_RST       = 8'h11;
    localparam logic [7:0]  UIFC_XOFF_RST      = 8'h13;
    localparam logic [7:0]  UIFC_ADDR_RST      = 8'h00;
    localparam logic [1:0]  UIFC_FC_HOST       = 2'h0;
    // Command register bits
    localparam int          UIFC_CMD_SEND_XON  = 0;
    localparam int          UIFC_CMD_SEND_XOFF = 1;
    // Interrupt status bits
    localparam int          UIFC_ISR_XON       = 0;
    localparam int          UIFC_ISR_XOFF      = 1;
    localparam int          UIFC_ISR_ADDR      = 2;
    localparam int          UIFC_ISR_W         = 3;
    // Fill thresholds
    localparam int          UIFC_XOFF_LEVEL    = 240;
    localparam int          UIFC_XON_LEVEL     = 128;
    localparam int          UIFC_LEVEL_W       = 9;
    localparam int          UIFC_STAT_W        = 3;
    // Emit state machine
    typedef enum logic [2:0] {
        UIFC_EM_IDLE = 3'b001,
        UIFC_EM_XOFF = 3'b010,
        UIFC_EM_XON  = 3'b100
    } uifc_emit_type;
endpackage

/* logic/uifc_sync_event.sv */
// Sticky event flags with mask: one bit per event, cleared by a status read.
// Assumes events and the read strobe are single-cycle pulses on core_clk.
`timescale 1ns/100ps
`default_nettype none
module uifc_sync_event #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Events and software access
    input  wire logic [W-1:0] event_set,
    input  wire logic         read_clear,
    input  wire logic [W-1:0] mask,
    // Results
    output logic      [W-1:0] status,
    output logic              irq
);
    logic [W-1:0] status_r;

    // ========================================================================
    // One flag per event; a set in the clearing cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_flag
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    status_r[gi] <= 1'b0;
                end else if (event_set[gi]) begin
                    status_r[gi] <= 1'b1;
                end else if (read_clear) begin
                    status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign status = status_r;
    assign irq    = |(status_r & mask);
endmodule
`default_nettype wire

/* logic/uifc_apb_regs.sv */
// APB slave register file for the in-band flow control block.
// Assumes a 32-bit APB master; answers in the access cycle, no wait states.
`timescale 1ns/100ps
`default_nettype none
module uifc_apb_regs
    import uifc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Register values
    output logic      [7:0]  mode,
    output logic      [7:0]  xon_char,
    output logic      [7:0]  xoff_char,
    output logic      [7:0]  addr_char,
    output logic      [UIFC_ISR_W-1:0] interrupt_mask,
    output logic             blk_err_mode,
    output logic      [1:0]  cmd_pulse,
    output logic             isr_read,
    // Read-back of block state
    input  wire logic [UIFC_ISR_W-1:0] isr,
    input  wire logic [UIFC_STAT_W-1:0] stat
);
    logic [7:0]  mode_r, xon_r, xoff_r, addr_r;
    logic [UIFC_ISR_W-1:0] imr_r;
    logic        blk_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;

    // ========================================================================
    // Decode
    wire       acc     = psel & penable;
    wire [9:0] idx     = paddr[11:2];
    wire       hit_mod = (idx == {2'b00, UIFC_IDX_MODE});
    wire       hit_cmd = (idx == {2'b00, UIFC_IDX_CMD});
    wire       hit_isr = (idx == {2'b00, UIFC_IDX_ISR});
    wire       hit_imr = (idx == {2'b00, UIFC_IDX_IMR});
    wire       hit_xon = (idx == {2'b00, UIFC_IDX_XON});
    wire       hit_xof = (idx == {2'b00, UIFC_IDX_XOFF});
    wire       hit_sta = (idx == {2'b00, UIFC_IDX_STAT});
    wire       hit_adr = (idx == {2'b00, UIFC_IDX_ADDR});
    wire       hit_rxm = (idx == {2'b00, UIFC_IDX_RXMODE});
    wire       mapped  = hit_mod | hit_cmd | hit_isr | hit_imr | hit_xon | hit_xof
                       | hit_sta | hit_adr | hit_rxm;
    wire       wr      = acc & pwrite & mapped;

    assign rd_mux = hit_mod ? {24'h000000, mode_r} :
                    hit_isr ? {29'h0000000, isr} :
                    hit_imr ? {29'h0000000, imr_r} :
                    hit_xon ? {24'h000000, xon_r} :
                    hit_xof ? {24'h000000, xoff_r} :
                    hit_sta ? {29'h0000000, stat} :
                    hit_adr ? {24'h000000, addr_r} :
                    hit_rxm ? {31'h0000000, blk_r} : 32'h00000000;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= UIFC_MODE_RST;
            xon_r  <= UIFC_XON_RST;
            xoff_r <= UIFC_XOFF_RST;
            addr_r <= UIFC_ADDR_RST;
            imr_r  <= '0;
            blk_r  <= 1'b0;
        end else if (wr) begin
            // Reserved bits 5:4 stay zero
            if (hit_mod) mode_r <= pwdata[7:0] & UIFC_MODE_WMASK;
            if (hit_xon) xon_r  <= pwdata[7:0];
            if (hit_xof) xoff_r <= pwdata[7:0];
            if (hit_adr) addr_r <= pwdata[7:0];
            if (hit_imr) imr_r  <= pwdata[UIFC_ISR_W-1:0];
            if (hit_rxm) blk_r  <= pwdata[0];
        end
    end

    // Read data driven combinationally in the access cycle, not registered
    assign prdata_r = (acc & ~pwrite) ? rd_mux : 32'h00000000;

    assign prdata       = prdata_r;
    assign pready       = 1'b1;
    assign pslverr      = acc & ~mapped;
    assign mode         = mode_r;
    assign xon_char     = xon_r;
    assign xoff_char    = xoff_r;
    assign addr_char    = addr_r;
    assign interrupt_mask          = imr_r;
    assign blk_err_mode = blk_r;
    assign cmd_pulse    = (wr & hit_cmd) ? pwdata[1:0] : 2'b00;
    assign isr_read     = acc & ~pwrite & hit_isr;
endmodule
`default_nettype wire

/* logic/uifc_top.sv */
// In-band Xon/Xoff flow control and recognised-character stripping for one UART channel.
// Assumes a receiver presenting one character per pulse, a transmitter that
// accepts one flow character on a request/grant handshake, and an APB master.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Flow-strip bit 7 set: recognised Xon/Xoff never enter the receive queue.
// - Address-strip bit 6 clear stores address characters; set discards them.
// - Stripped character's status is dropped, except errors feed block error status.
// - Recognition interrupts do not depend on stripping bits.
// - Mode 00: no automatic action; host commands send flow characters.
// - Mode 01: received Xoff pauses transmitter, Xon resumes it.
// - Mode 10 auto receive only; mode 11 both automatic directions.
// - Auto receive: send Xoff when queue fill reaches 240.
// - After Xoff, send Xon when queue drains to 128 or fewer.
// - Mode not 00: host Xon/Xoff send commands are ignored.
// - Every received flow character raises interrupt when mask enables it.
// - Reading the flow interrupt status clears it; host must read to acknowledge.
// - Mode bits steer only automatic gating and emission, never interrupts.
// - Set strip bit discards class regardless of mode fields.
module uifc_top
    import uifc_pkg::*;
#(
    parameter int LEVEL_W = UIFC_LEVEL_W
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // APB
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Receiver side
    input  wire logic               rx_valid,
    input  wire logic [7:0]         rx_char,
    input  wire logic [2:0]         rx_err,
    input  wire logic [LEVEL_W-1:0] rx_level,
    // Receive queue write side
    output logic                    rxq_wr,
    output logic      [7:0]         rxq_char,
    output logic      [2:0]         rxq_err,
    output logic      [2:0]         blk_err_acc,
    // Transmitter side
    output logic                    tx_enable,
    output logic                    tx_fc_req,
    output logic      [7:0]         tx_fc_char,
    input  wire logic               tx_fc_grant,
    // Interrupt
    output logic                    irq
);
    logic [7:0]            mode, xon_c, xoff_c, addr_c;
    logic [UIFC_ISR_W-1:0] interrupt_mask, isr;
    logic                  blk_mode, isr_read;
    logic [1:0]            cmd;
    logic                  tx_paused_r, xoff_sent_r;
    logic                  rxq_wr_r;
    logic [7:0]            rxq_char_r;
    logic [2:0]            rxq_err_r, blk_err_r;
    uifc_emit_type         em_r, em_nxt;

    // ========================================================================
    // Registers and interrupt flags
    uifc_apb_regs u_regs (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .mode         (mode),
        .xon_char     (xon_c),
        .xoff_char    (xoff_c),
        .addr_char    (addr_c),
        .interrupt_mask          (interrupt_mask),
        .blk_err_mode (blk_mode),
        .cmd_pulse    (cmd),
        .isr_read     (isr_read),
        .isr          (isr),
        .stat         ({xoff_sent_r, tx_paused_r, blk_mode})
    );

    // ========================================================================
    // Recognition and stripping
    wire [1:0] fc_mode  = mode[UIFC_MODE_FC_LO+1:UIFC_MODE_FC_LO];
    wire       auto_tx  = fc_mode[0];
    wire       auto_rx  = fc_mode[1];
    wire       is_xon   = rx_valid & (rx_char == xon_c);
    wire       is_xoff  = rx_valid & (rx_char == xoff_c);
    wire       is_addr  = rx_valid & (rx_char == addr_c) & ~is_xon & ~is_xoff;
    wire       strip_fc = (is_xon | is_xoff) & mode[UIFC_MODE_FC_STRIP];
    wire       strip_ad = is_addr & mode[UIFC_MODE_AD_STRIP];
    wire       store    = rx_valid & ~strip_fc & ~strip_ad;

    // Interrupt sources ignore both strip bits and mode field
    wire [UIFC_ISR_W-1:0] ev = {is_addr, is_xoff, is_xon};

    uifc_sync_event #(.W(UIFC_ISR_W)) u_evt (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .event_set  (ev),
        .read_clear (isr_read),
        .mask       (interrupt_mask),
        .status     (isr),
        .irq        (irq)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxq_wr_r   <= 1'b0;
            rxq_char_r <= 8'h00;
            rxq_err_r  <= 3'h0;
        end else begin
            rxq_wr_r   <= store;
            rxq_char_r <= rx_char;
            rxq_err_r  <= store ? rx_err : 3'h0;
        end
    end

    // Block error accumulation counts stripped characters too
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_err_r <= 3'h0;
        end else if (!blk_mode) begin
            blk_err_r <= 3'h0;
        end else if (rx_valid) begin
            blk_err_r <= blk_err_r | rx_err;
        end
    end

    // ========================================================================
    // Automatic transmitter gating
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_paused_r <= 1'b0;
        end else if (!auto_tx) begin
            tx_paused_r <= 1'b0;
        end else if (is_xoff) begin
            tx_paused_r <= 1'b1;
        end else if (is_xon) begin
            tx_paused_r <= 1'b0;
        end
    end

    // ========================================================================
    // Flow character emission
    wire host_mode = (fc_mode == UIFC_FC_HOST);
    wire hit_high  = auto_rx & (rx_level >= LEVEL_W'(UIFC_XOFF_LEVEL)) & ~xoff_sent_r;
    wire hit_low   = auto_rx & (rx_level <= LEVEL_W'(UIFC_XON_LEVEL)) & xoff_sent_r;
    wire cmd_xoff  = host_mode & cmd[UIFC_CMD_SEND_XOFF];
    wire cmd_xon   = host_mode & cmd[UIFC_CMD_SEND_XON];

    always_comb begin
        em_nxt = em_r;
        case (em_r)
            UIFC_EM_IDLE: begin
                if (hit_high || cmd_xoff) begin
                    em_nxt = UIFC_EM_XOFF;
                end else if (hit_low || cmd_xon) begin
                    em_nxt = UIFC_EM_XON;
                end
            end
            UIFC_EM_XOFF: begin
                if (tx_fc_grant) em_nxt = UIFC_EM_IDLE;
            end
            UIFC_EM_XON: begin
                if (tx_fc_grant) em_nxt = UIFC_EM_IDLE;
            end
            default: em_nxt = UIFC_EM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            em_r        <= UIFC_EM_IDLE;
            xoff_sent_r <= 1'b0;
        end else begin
            em_r <= em_nxt;
            // Leaving auto receive forgets a pending Xon obligation
            if (!auto_rx) begin
                xoff_sent_r <= 1'b0;
            end else if (tx_fc_grant && em_r == UIFC_EM_XOFF) begin
                xoff_sent_r <= 1'b1;
            end else if (tx_fc_grant && em_r == UIFC_EM_XON) begin
                xoff_sent_r <= 1'b0;
            end
        end
    end

    assign tx_fc_req   = (em_r != UIFC_EM_IDLE);
    assign tx_fc_char  = (em_r == UIFC_EM_XOFF) ? xoff_c : xon_c;
    assign tx_enable   = ~tx_paused_r;
    assign rxq_wr      = rxq_wr_r;
    assign rxq_char    = rxq_char_r;
    assign rxq_err     = rxq_err_r;
    assign blk_err_acc = blk_err_r;

    // ========================================================================
    // Checks
    AST_FC_STRIP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_xon | is_xoff) && mode[UIFC_MODE_FC_STRIP] |=> !rxq_wr)
        else $error("stripped flow character stored");
    AST_AD_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_addr && !mode[UIFC_MODE_AD_STRIP] |=> rxq_wr && rxq_char == $past(rx_char))
        else $error("address character not stored");
    AST_ERR_DROP: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rxq_wr |-> rxq_err == 3'h0)
        else $error("status of dropped character kept");
    AST_IRQ_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_xoff |=> isr[UIFC_ISR_XOFF])
        else $error("flow interrupt flag not set");
    AST_PAUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
        auto_tx && is_xoff ##1 auto_tx |-> !tx_enable)
        else $error("transmitter not paused on Xoff");
    AST_HOST_IGN: assert property (@(posedge core_clk) disable iff (!rst_n)
        em_r == UIFC_EM_IDLE && !host_mode && !auto_rx |=> em_r == UIFC_EM_IDLE)
        else $error("host command acted outside host mode");
    AST_XOFF_EMIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        em_r == UIFC_EM_IDLE && hit_high |=> tx_fc_req && tx_fc_char == xoff_c)
        else $error("Xoff not requested at high level");
    AST_ISR_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
        isr_read && ev == '0 |=> isr == '0)
        else $error("status read did not clear flags");
    AST_AUTO_NO: assert property (@(posedge core_clk) disable iff (!rst_n)
        host_mode |=> tx_enable)
        else $error("automatic gating in host mode");
    COV_XOFF: cover property (@(posedge core_clk) tx_fc_req && tx_fc_grant && em_r == UIFC_EM_XOFF);
    COV_PAUSE: cover property (@(posedge core_clk) !tx_enable ##[1:50] tx_enable);
    COV_STRIP: cover property (@(posedge core_clk) strip_fc);
endmodule
`default_nettype wire

/* testbench/uifc_far_station.sv */
// Far serial station model: feeds received characters, accepts flow characters.
// Assumes the block's request/grant handshake for emitted flow characters.
`timescale 1ns/100ps
`default_nettype none
module uifc_far_station (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Line side
    input  wire logic       slow,
    input  wire logic       tx_fc_req,
    input  wire logic [7:0] tx_fc_char,
    output logic            tx_fc_grant,
    output logic            rx_valid,
    output logic      [7:0] rx_char,
    output logic      [2:0] rx_err,
    // Observation
    output logic      [7:0] last_fc,
    output int              n_fc
);
    int dly;
    initial begin
        rx_valid = 1'b0;
        rx_char  = 8'hFF;
        rx_err   = 3'h7;
    end
    // ========================================================================
    // Grant after one or four cycles; the slow case proves the request holds
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_fc_grant <= 1'b0;
            dly         <= 0;
            n_fc        <= 0;
            last_fc     <= 8'h00;
        end else if (tx_fc_grant) begin
            tx_fc_grant <= 1'b0;
            dly         <= 0;
            last_fc     <= tx_fc_char;
            n_fc        <= n_fc + 1;
        end else if (tx_fc_req) begin
            if (dly >= (slow ? 3 : 0)) tx_fc_grant <= 1'b1;
            else dly <= dly + 1;
        end
    end
    // ========================================================================
    // One character per call; idle lines show the inverse so stale data never matches
    task put(input logic [7:0] c, input logic [2:0] e);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_char  <= c;
        rx_err   <= e;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_char  <= ~c;
        rx_err   <= ~e;
    endtask
endmodule
`default_nettype wire

/* testbench/uifc_top_tb.sv */
// Self-checking bench for the in-band flow control block.
// Assumes the far station model and an APB master built here.
`timescale 1ns/100ps
`default_nettype none
module uifc_top_tb
    import uifc_pkg::*;
;
    logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, rx_valid, rxq_wr, tx_enable, tx_fc_req, tx_fc_grant, irq;
    logic slow = 1'b0;
    logic [7:0] rx_char, rxq_char, tx_fc_char, last_fc, c;
    logic [2:0] rx_err, rxq_err, blk_err_acc;
    logic [10:0] q_last;
    logic [8:0] rx_level = 9'h000;
    int fails = 0, total_checks = 0, seed = 32'h1ff0, cyc = 0, stored = 0, n_fc, n0;
    always #5 core_clk = ~core_clk;
    uifc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_char(rx_char), .rx_err(rx_err),
        .rx_level(rx_level), .rxq_wr(rxq_wr), .rxq_char(rxq_char), .rxq_err(rxq_err),
        .blk_err_acc(blk_err_acc), .tx_enable(tx_enable), .tx_fc_req(tx_fc_req),
        .tx_fc_char(tx_fc_char), .tx_fc_grant(tx_fc_grant), .irq(irq));
    uifc_far_station far (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
        .tx_fc_req(tx_fc_req), .tx_fc_char(tx_fc_char), .tx_fc_grant(tx_fc_grant),
        .rx_valid(rx_valid), .rx_char(rx_char), .rx_err(rx_err), .last_fc(last_fc),
        .n_fc(n_fc));
    // ========================================================================
    // Checking and closing
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        // Queue data is only meaningful while the write pulse stands
        if (rxq_wr === 1'b1) begin
            stored++;
            q_last = {rxq_char, rxq_err};
        end
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    // ========================================================================
    // APB master: holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task send(input logic [7:0] ch, input logic [2:0] e);
        far.put(ch, e);
        repeat (2) @(posedge core_clk);
    endtask
    task wait_fc(input int n);
        repeat (60) if (n_fc != n) @(posedge core_clk);
        chk("fc_count", n_fc, n);
    endtask
    function automatic logic [31:0] mode_word(logic fs, logic as, logic [1:0] fm);
        return {24'h0, fs, as, 2'b00, fm, 2'b00};
    endfunction
    // ========================================================================
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(0, UIFC_IDX_MODE, 0);  chk("mode_rst", rd, 32'h0);
        apb(0, UIFC_IDX_XON, 0);   chk("xon_rst", rd, {24'h0, UIFC_XON_RST});
        apb(0, UIFC_IDX_XOFF, 0);  chk("xoff_rst", rd, {24'h0, UIFC_XOFF_RST});
        apb(0, 8'h3F, 0);          chk("unmapped_err", er, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        apb(1, UIFC_IDX_IMR, 7);
        // Stripping for every strip pair under flow modes 00 and 10
        for (int k = 0; k < 8; k++) begin
            apb(1, UIFC_IDX_MODE, mode_word(k[1], k[0], (k < 4) ? 2'h0 : 2'h2));
            n0 = stored;
            c = {1'b1, 7'($random(seed))};
            send(UIFC_XON_RST, 3'h0);
            send(UIFC_XOFF_RST, 3'h0);
            send(UIFC_ADDR_RST, 3'h0);
            send(c, 3'h5);
            chk("last_char", q_last, {c, 3'h5});
            chk("stored", stored - n0, (k[1] ? 0 : 2) + (k[0] ? 0 : 1) + 1);
            chk("irq_set", irq, 1'b1);
            apb(0, UIFC_IDX_ISR, 0);   chk("isr", rd, 32'h7);
            // The clear lands at the access edge; look one edge later
            @(posedge core_clk);
            chk("irq_clr", irq, 1'b0);
        end
        // Stripped character's errors still reach the block error status
        apb(1, UIFC_IDX_RXMODE, 1);
        send(UIFC_XON_RST, 3'h6);
        chk("blk_err", blk_err_acc, 3'h6);
        apb(1, UIFC_IDX_RXMODE, 0);
        // Masked interrupt stays low but status still records
        apb(1, UIFC_IDX_IMR, 0);
        send(UIFC_XON_RST, 3'h0);
        chk("irq_masked", irq, 1'b0);
        apb(0, UIFC_IDX_ISR, 0);   chk("isr_masked", rd, 32'h1);
        // Transmit gating per mode with reprogrammed codes
        apb(1, UIFC_IDX_XON, 32'h5A);
        apb(1, UIFC_IDX_XOFF, 32'hA5);
        for (int m = 0; m < 4; m++) begin
            apb(1, UIFC_IDX_MODE, mode_word(0, 0, 2'(m)));
            send(8'hA5, 3'h0);
            chk("tx_paused", tx_enable, (m[0] ? 1'b0 : 1'b1));
            send(8'h5A, 3'h0);
            chk("tx_resumed", tx_enable, 1'b1);
            apb(0, UIFC_IDX_ISR, 0);   chk("isr_mode", rd, 32'h3);
        end
        // Host commands: honoured only in mode 00
        apb(1, UIFC_IDX_MODE, mode_word(0, 0, 2'h0));
        apb(1, UIFC_IDX_CMD, 32'h2);
        wait_fc(1);
        chk("host_xoff", last_fc, 8'hA5);
        apb(1, UIFC_IDX_MODE, mode_word(0, 0, 2'h2));
        apb(1, UIFC_IDX_CMD, 32'h1);
        repeat (10) @(posedge core_clk);
        chk("cmd_ignored", n_fc, 1);
        // Fill thresholds with a slow transmitter
        slow <= 1'b1;
        rx_level <= 9'd239;
        repeat (10) @(posedge core_clk);
        chk("below_240", n_fc, 1);
        rx_level <= 9'd240;
        wait_fc(2);
        chk("auto_xoff", last_fc, 8'hA5);
        apb(0, UIFC_IDX_STAT, 0);  chk("stat_xoff_sent", rd, 32'h4);
        rx_level <= 9'd129;
        repeat (10) @(posedge core_clk);
        chk("above_128", n_fc, 2);
        rx_level <= 9'd128;
        wait_fc(3);
        chk("auto_xon", last_fc, 8'h5A);
        results();
    end
endmodule
`default_nettype wire
